// >>> core/cspst_pkg.sv
// Shared constants and types for the chip select priority and stretch block
package cspst_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses on the low address bits)
	// ------------------------------------------------------------------
	localparam logic [7:0]  STR0_IDX     = 8'h3E;
	localparam logic [7:0]  STR1_IDX     = 8'h3F;
	localparam logic [9:0]  STR0_ADDR    = {STR0_IDX, 2'b00};
	localparam logic [9:0]  STR1_ADDR    = {STR1_IDX, 2'b00};
	localparam logic [9:0]  CFG_ADDR     = 10'h000;
	localparam logic [9:0]  MAP_ADDR     = 10'h004;
	localparam logic [9:0]  STAT_ADDR    = 10'h008;
	localparam logic [1:0]  HTRANS_NSEQ  = 2'b10;
	localparam logic [2:0]  HSIZE_WORD   = 3'b010;

	// ------------------------------------------------------------------
	// Select indices, also the rank order (0 is highest)
	// ------------------------------------------------------------------
	localparam int NUM_SEL  = 7;
	localparam int SEL_CS3  = 0;
	localparam int SEL_CS2  = 1;
	localparam int SEL_CS1  = 2;
	localparam int SEL_CS0  = 3;
	localparam int SEL_PROGRAM_SELECT_ZERO = 4;
	localparam int SEL_CSD  = 5;
	localparam int SEL_PROGRAM_SELECT_ONE = 6;

	// ------------------------------------------------------------------
	// Configuration fields and reset values
	// ------------------------------------------------------------------
	localparam int CFG_FOLLOW_BIT = 8;
	localparam int CFG_EXTRA_WINDOW_ENABLE_BIT   = 9;
	localparam int CFG_EEPROM_MAP_ENABLE_BIT   = 10;
	localparam int CFG_EXPAND_BIT = 11;
	localparam int CFG_DEBUG_BIT  = 12;
	localparam int CFG_EPLOC_BIT  = 13;
	localparam int CFG_P1FULL_BIT = 14;
	localparam int CFG_DHALF_BIT  = 15;
	localparam int MAP_REGB_LSB   = 0;
	localparam int MAP_RAMB_LSB   = 8;
	localparam int MAP_EEB_LSB    = 16;
	localparam logic [15:0] CFG_RST  = 16'h0010;
	localparam logic [31:0] MAP_RST  = 32'h000F_0100;
	localparam logic [7:0]  STR0_RST = 8'h3F;
	localparam logic [7:0]  STR1_RST = 8'hFF;

	// ------------------------------------------------------------------
	// Address space shapes
	// ------------------------------------------------------------------
	localparam logic [1:0] REG_BLK = 2'b00;
	localparam logic [1:0] CSR_BLK = 2'b01;
	localparam logic [7:0] DBG_PAGE = 8'hFF;
	localparam logic [1:0] P_TOP = 2'b10;
	localparam logic [3:0] D_TOP = 4'h7;
	localparam logic [1:0] CS3_OFS = 2'b01;
	localparam logic [1:0] CS2_OFS = 2'b11;

	typedef enum logic [3:0] {
		OWN_NONE     = 4'h0,
		OWN_REG      = 4'h1,
		OWN_DBG      = 4'h2,
		OWN_RAM      = 4'h3,
		OWN_EE       = 4'h4,
		OWN_EXT_E    = 4'h5,
		OWN_EXT_CS   = 4'h6,
		OWN_EXT_P    = 4'h7,
		OWN_EXT_D    = 4'h8,
		OWN_EXT_REST = 4'h9
	} cspst_owner_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACCESS  = 2'b01,
		ST_STRETCH = 2'b10
	} cspst_state_t;

endpackage : cspst_pkg

// >>> core/cspst_decode.sv
// Address decoder: owner of an access and the one chip select it drives
`timescale 1ns/1ps
`default_nettype none
module cspst_decode
	import cspst_pkg::*;
(
	input  wire logic [15:0]         addr,
	input  wire logic [15:0]         cfg,
	input  wire logic [31:0]         map,
	output cspst_pkg::cspst_owner_t  owner,
	output logic [6:0]               cand,
	output logic [6:0]               sel
);
	logic [4:0] regb;
	logic [5:0] ramb;
	logic [3:0] eeb;
	logic       ext;
	logic [7:0] blk;

	assign regb = map[MAP_REGB_LSB +: 5];
	assign ramb = map[MAP_RAMB_LSB +: 6];
	assign eeb  = map[MAP_EEB_LSB +: 4];

	always_comb begin
		owner = OWN_NONE;
		if (addr[15:11] == regb && addr[10:9] == REG_BLK) begin
			owner = OWN_REG;
		end else if (cfg[CFG_DEBUG_BIT] && addr[15:8] == DBG_PAGE) begin
			owner = OWN_DBG;
		end else if (addr[15:10] == ramb) begin
			owner = OWN_RAM;
		end else if (cfg[CFG_EEPROM_MAP_ENABLE_BIT] && addr[15:12] == eeb) begin
			owner = OWN_EE;
		end else if (!cfg[CFG_EXPAND_BIT]) begin
			owner = OWN_NONE;
		end else if (cfg[CFG_EXTRA_WINDOW_ENABLE_BIT]
			&& addr[15:10] == {5'b0_0000, cfg[CFG_EPLOC_BIT]}) begin
			owner = OWN_EXT_E;
		end else if (addr[15:11] == regb && addr[10:9] == CSR_BLK) begin
			owner = OWN_EXT_CS;
		end else if (addr[15:14] == P_TOP) begin
			owner = OWN_EXT_P;
		end else if (addr[15:12] == D_TOP) begin
			owner = OWN_EXT_D;
		end else begin
			owner = OWN_EXT_REST;
		end
	end

	// Only external owners may raise a select; on-chip wins outright
	assign ext = (owner >= OWN_EXT_E);

	always_comb begin
		cand = 7'h00;
		// Follow mode needs the extra window enabled to ever hit
		cand[SEL_CS3] = cfg[SEL_CS3] && (cfg[CFG_FOLLOW_BIT]
			? (owner == OWN_EXT_E)
			: (owner == OWN_EXT_CS && addr[8:7] == CS3_OFS));
		cand[SEL_CS2] = cfg[SEL_CS2] && owner == OWN_EXT_CS
			&& addr[8:7] == CS2_OFS;
		cand[SEL_CS1] = cfg[SEL_CS1] && owner == OWN_EXT_CS && addr[8];
		cand[SEL_CS0] = cfg[SEL_CS0] && owner == OWN_EXT_CS;
		cand[SEL_PROGRAM_SELECT_ZERO] = cfg[SEL_PROGRAM_SELECT_ZERO] && ext && addr[15];
		cand[SEL_CSD] = cfg[SEL_CSD] && ext && (cfg[CFG_DHALF_BIT]
			? !addr[15] : owner == OWN_EXT_D);
		cand[SEL_PROGRAM_SELECT_ONE] = cfg[SEL_PROGRAM_SELECT_ONE] && ext
			&& (cfg[CFG_P1FULL_BIT] || addr[15]);
	end

	// Fixed rank: a lower index blocks every later one
	assign blk[0] = 1'b0;
	for (genvar i = 0; i < NUM_SEL; i++) begin : g_rank
		assign sel[i]   = cand[i] && !blk[i];
		assign blk[i+1] = blk[i] || cand[i];
	end

endmodule : cspst_decode
`default_nettype wire

// >>> core/cspst_stretch.sv
// Down counter that times the added E cycles of a stretched access
`timescale 1ns/1ps
`default_nettype none
module cspst_stretch (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       load,
	input  wire logic [1:0] count,
	input  wire logic       run,
	output logic            last
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = count;
		end else if (run && cnt_q != 2'd0) begin
			cnt_d = cnt_q - 2'd1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 2'd0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign last = (cnt_q == 2'd1);

endmodule : cspst_stretch
`default_nettype wire

// >>> core/cspst_top.sv
// Chip select priority decode, stretch timing and AHB-Lite register file
// Behaviour
// - Select three covers the second 128 bytes after registers
// - Following, select three covers extra page window
// - Each of seven selects has 2-bit stretch
// - Stretch codes add zero to three E cycles
// - Only one module or select per access
// - Overlapping modules: highest ranked one wins
// - Registers top priority, full 512-byte block
// - Debug page FFxx ranks below registers
// - EEPROM decodes below RAM only when enabled
// - Extra page, then register-following space, below EEPROM
// - Program window ranks below register-following space
// - Data window above rest, rest lowest
// - External spaces only reachable in expanded mode
// - At most one select active per address
// - Rank: three, two, one, zero, P0, D, P1
// - Selects are active low
// - Single-chip mode leaves select pins idle
`timescale 1ns/1ps
`default_nettype none
module cspst_top (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic                cpu_req,
	input  wire logic [15:0]         cpu_addr,
	output logic                     cpu_ready,
	output logic                     access_done,
	output logic                     bus_cycle,
	output logic [15:0]              ext_addr,
	output logic [6:0]               select_n,
	output cspst_pkg::cspst_owner_t  owner
);
	import cspst_pkg::*;

	// ------------------------------------------------------------------
	// Register file over AHB-Lite
	// ------------------------------------------------------------------
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	logic [31:0] map_q;
	logic [31:0] map_d;
	logic [7:0]  str0_q;
	logic [7:0]  str0_d;
	logic [7:0]  str1_q;
	logic [7:0]  str1_d;
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [9:0]  wr_addr_q;
	logic [9:0]  wr_addr_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic        addr_ok;
	logic [31:0] rd_val;
	logic [1:0]  stretch_q;
	logic [1:0]  stretch_d;

	assign addr_ok = hsel && hready && htrans == HTRANS_NSEQ;

	always_comb begin
		case (haddr[9:0])
			CFG_ADDR:  rd_val = {16'h0000, cfg_q};
			MAP_ADDR:  rd_val = map_q;
			STAT_ADDR: rd_val = {15'h0000, bus_cycle, 1'b0, ~select_n,
				2'b00, stretch_q, owner};
			STR0_ADDR: rd_val = {24'h00_0000, 2'b00, str0_q[5:0]};
			STR1_ADDR: rd_val = {24'h00_0000, str1_q};
			default:   rd_val = 32'h0000_0000;
		endcase
	end

	always_comb begin
		wr_pend_d = addr_ok && hwrite && hsize == HSIZE_WORD;
		wr_addr_d = haddr[9:0];
		hrdata_d  = (addr_ok && !hwrite) ? rd_val : hrdata_q;
		cfg_d     = cfg_q;
		map_d     = map_q;
		str0_d    = str0_q;
		str1_d    = str1_q;
		if (wr_pend_q) begin
			case (wr_addr_q)
				CFG_ADDR:  cfg_d  = hwdata[15:0];
				MAP_ADDR:  map_d  = {12'h000, hwdata[19:16], 2'b00,
					hwdata[13:8], 3'b000, hwdata[4:0]};
				STR0_ADDR: str0_d = {2'b00, hwdata[5:0]};
				STR1_ADDR: str1_d = hwdata[7:0];
				default:   cfg_d  = cfg_q;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q     <= CFG_RST;
			map_q     <= MAP_RST;
			str0_q    <= STR0_RST;
			str1_q    <= STR1_RST;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 10'h000;
			hrdata_q  <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			map_q     <= map_d;
			str0_q    <= str0_d;
			str1_q    <= str1_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;

	// ------------------------------------------------------------------
	// Decode and stretch selection
	// ------------------------------------------------------------------
	cspst_owner_t dec_owner;
	logic [6:0]   dec_cand;
	logic [6:0]   dec_sel;
	logic [1:0]   sel_str [NUM_SEL];
	logic [1:0]   dec_str;

	cspst_decode u_decode (
		.addr  (cpu_addr),
		.cfg   (cfg_q),
		.map   (map_q),
		.owner (dec_owner),
		.cand  (dec_cand),
		.sel   (dec_sel)
	);

	assign sel_str[SEL_CSD]  = str0_q[1:0];
	assign sel_str[SEL_PROGRAM_SELECT_ZERO] = str0_q[3:2];
	assign sel_str[SEL_PROGRAM_SELECT_ONE] = str0_q[5:4];
	assign sel_str[SEL_CS0]  = str1_q[1:0];
	assign sel_str[SEL_CS1]  = str1_q[3:2];
	assign sel_str[SEL_CS2]  = str1_q[5:4];
	assign sel_str[SEL_CS3]  = str1_q[7:6];

	// One-hot select: OR of the winner's field; no select, no stretch
	always_comb begin
		dec_str = 2'd0;
		for (int i = 0; i < NUM_SEL; i++) begin
			dec_str = dec_str | (dec_sel[i] ? sel_str[i] : 2'd0);
		end
	end

	// ------------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------------
	cspst_state_t state_q;
	cspst_state_t state_d;
	logic [15:0]  ext_addr_d;
	logic [6:0]   select_n_d;
	cspst_owner_t owner_d;
	logic         bus_d;
	logic         done_d;
	logic         ready_d;
	logic         cnt_load;
	logic         cnt_last;

	cspst_stretch u_stretch (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (cnt_load),
		.count   (stretch_q),
		.run     (state_q == ST_STRETCH),
		.last    (cnt_last)
	);

	always_comb begin
		state_d    = state_q;
		ext_addr_d = ext_addr;
		select_n_d = select_n;
		owner_d    = owner;
		stretch_d  = stretch_q;
		bus_d      = bus_cycle;
		done_d     = 1'b0;
		ready_d    = cpu_ready;
		cnt_load   = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (cpu_req) begin
					ext_addr_d = cpu_addr;
					select_n_d = ~dec_sel;
					owner_d    = dec_owner;
					stretch_d  = dec_str;
					bus_d      = 1'b1;
					ready_d    = 1'b0;
					state_d    = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (stretch_q == 2'd0) begin
					select_n_d = 7'h7F;
					bus_d      = 1'b0;
					done_d     = 1'b1;
					ready_d    = 1'b1;
					state_d    = ST_IDLE;
				end else begin
					cnt_load = 1'b1;
					state_d  = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				// Address and select stay frozen until the count ends
				if (cnt_last) begin
					select_n_d = 7'h7F;
					bus_d      = 1'b0;
					done_d     = 1'b1;
					ready_d    = 1'b1;
					state_d    = ST_IDLE;
				end
			end
			default: begin
				select_n_d = 7'h7F;
				bus_d      = 1'b0;
				ready_d    = 1'b1;
				state_d    = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q     <= ST_IDLE;
			ext_addr    <= 16'h0000;
			select_n    <= 7'h7F;
			owner       <= OWN_NONE;
			stretch_q   <= 2'd0;
			bus_cycle   <= 1'b0;
			access_done <= 1'b0;
			cpu_ready   <= 1'b1;
		end else begin
			state_q     <= state_d;
			ext_addr    <= ext_addr_d;
			select_n    <= select_n_d;
			owner       <= owner_d;
			stretch_q   <= stretch_d;
			bus_cycle   <= bus_d;
			access_done <= done_d;
			cpu_ready   <= ready_d;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_one_select;
		@(posedge hclk) disable iff (!hresetn)
		$onehot0(~select_n);
	endproperty
	a_one_select: assert property (p_one_select)
		else $error("More than one select active");

	property p_rank;
		@(posedge hclk) disable iff (!hresetn)
		dec_cand[SEL_CS3] && dec_cand[SEL_CS0] |-> dec_sel == 7'h01;
	endproperty
	a_rank: assert property (p_rank)
		else $error("Select three did not outrank select zero");

	property p_cs3_fixed;
		@(posedge hclk) disable iff (!hresetn)
		!cfg_q[CFG_FOLLOW_BIT] && dec_sel[SEL_CS3]
			|-> dec_owner == OWN_EXT_CS && cpu_addr[8:7] == CS3_OFS;
	endproperty
	a_cs3_fixed: assert property (p_cs3_fixed)
		else $error("Select three outside its 128-byte area");

	property p_cs3_follow;
		@(posedge hclk) disable iff (!hresetn)
		cfg_q[CFG_FOLLOW_BIT] && cfg_q[SEL_CS3] && dec_owner == OWN_EXT_E
			|-> dec_sel == 7'h01;
	endproperty
	a_cs3_follow: assert property (p_cs3_follow)
		else $error("Select three missed extra page access");

	property p_stretch3;
		@(posedge hclk) disable iff (!hresetn)
		$rose(bus_cycle) && stretch_q == 2'd3
			|-> bus_cycle[*4] ##1 (!bus_cycle && access_done);
	endproperty
	a_stretch3: assert property (p_stretch3)
		else $error("Stretch of three did not last four cycles");

	property p_stretch0;
		@(posedge hclk) disable iff (!hresetn)
		$rose(bus_cycle) && stretch_q == 2'd0 |=> !bus_cycle && access_done;
	endproperty
	a_stretch0: assert property (p_stretch0)
		else $error("Unstretched access not one cycle");

	property p_hold;
		@(posedge hclk) disable iff (!hresetn)
		bus_cycle && $past(bus_cycle) |-> $stable(ext_addr)
			&& $stable(select_n);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Address or select moved inside access");

	property p_reg_top;
		@(posedge hclk) disable iff (!hresetn)
		cpu_addr[15:11] == map_q[MAP_REGB_LSB +: 5]
			&& cpu_addr[10:9] == REG_BLK |-> dec_owner == OWN_REG;
	endproperty
	a_reg_top: assert property (p_reg_top)
		else $error("Register block lost priority");

	property p_ee_off;
		@(posedge hclk) disable iff (!hresetn)
		!cfg_q[CFG_EEPROM_MAP_ENABLE_BIT] |-> dec_owner != OWN_EE;
	endproperty
	a_ee_off: assert property (p_ee_off)
		else $error("Disabled EEPROM decoded");

	property p_single_chip;
		@(posedge hclk) disable iff (!hresetn)
		!cfg_q[CFG_EXPAND_BIT] && $rose(bus_cycle) |-> select_n == 7'h7F;
	endproperty
	a_single_chip: assert property (p_single_chip)
		else $error("Select driven in single-chip mode");

	property p_low_only_in_cycle;
		@(posedge hclk) disable iff (!hresetn)
		select_n != 7'h7F |-> bus_cycle;
	endproperty
	a_low_only_in_cycle: assert property (p_low_only_in_cycle)
		else $error("Select low outside a bus cycle");

	c_stretch3: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(bus_cycle) && stretch_q == 2'd3);
	c_follow: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(bus_cycle) && !select_n[SEL_CS3] && owner == OWN_EXT_E);
	c_reg: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(bus_cycle) && owner == OWN_REG);

endmodule : cspst_top
`default_nettype wire

// >>> tb/cspst_ext_mem.sv
// Model of the external memories and peripherals on the expansion bus
`timescale 1ns/1ps
`default_nettype none
module cspst_ext_mem (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        bus_cycle,
	input  wire logic [15:0] ext_addr,
	input  wire logic [6:0]  select_n,
	output logic [3:0]       last_len,
	output logic [6:0]       last_sel,
	output logic [7:0]       n_slip
);
	logic [3:0]  len;
	logic [15:0] adr;

	// ------------------------------------------------------------------
	// Devices wake on a low select and finish as it is released
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			len <= 4'h0;
			adr <= 16'h0000;
			last_len <= 4'h0;
			last_sel <= 7'h00;
			n_slip <= 8'h00;
		end else if (select_n != 7'h7F) begin
			if (len == 4'h0) begin
				adr <= ext_addr;
			end else if (ext_addr != adr || !bus_cycle) begin
				n_slip <= n_slip + 8'h01;
			end
			len <= len + 4'h1;
			last_sel <= ~select_n;
		end else if (len != 4'h0) begin
			// Transfer completes on the first clock after the select is released
			last_len <= len;
			len <= 4'h0;
		end
	end

endmodule : cspst_ext_mem
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the chip select priority and stretch block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cspst_pkg::*;
	logic               hclk = 1'b0;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic [31:0]        haddr = 32'h0000_0000;
	logic [1:0]         htrans = 2'b00;
	logic               hwrite = 1'b0;
	logic [2:0]         hsize = HSIZE_WORD;
	logic [31:0]        hwdata = 32'h0000_0000;
	logic               cpu_req = 1'b0;
	logic [15:0]        cpu_addr = 16'h0000;
	wire logic          hready;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               hresp;
	logic               cpu_ready;
	logic               access_done;
	logic               bus_cycle;
	logic [15:0]        ext_addr;
	logic [6:0]         select_n;
	cspst_owner_t       owner;
	logic [3:0]         m_len;
	logic [6:0]         m_sel;
	logic [7:0]         m_slip;
	int                 n_mismatch = 0;
	int                 n_compared = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	cspst_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_ready(cpu_ready),
		.access_done(access_done), .bus_cycle(bus_cycle),
		.ext_addr(ext_addr), .select_n(select_n), .owner(owner));

	cspst_ext_mem i_mem (.hclk(hclk), .hresetn(hresetn),
		.bus_cycle(bus_cycle), .ext_addr(ext_addr), .select_n(select_n),
		.last_len(m_len), .last_sel(m_sel), .n_slip(m_slip));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tmo(input int k);
		if (k >= 50) begin
			n_mismatch++;
			$display("[ERR] handshake wait expected 1 seen 0");
			end_sim();
		end
	endtask : tmo

	task automatic ahb(input logic wr, input logic [9:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		int k;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		hwrite <= wr;
		htrans <= HTRANS_NSEQ;
		for (k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		tmo(k);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		for (k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		tmo(k);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk("register read", exp, q);
	endtask : rdchk

	// One access; sel below zero means no select, n is the stretch
	task automatic acc(input logic [15:0] a, input cspst_owner_t own,
		input int sel, input int n);
		logic [6:0] es;
		int k;
		es = (sel < 0) ? 7'h7F : ~(7'h01 << sel);
		@(posedge hclk);
		cpu_req <= 1'b1;
		cpu_addr <= a;
		for (k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (cpu_ready === 1'b1) break;
		end
		tmo(k);
		// New address while busy must be ignored
		cpu_req <= 1'b0;
		cpu_addr <= ~a;
		#1;
		chk("owner", {28'h0, own}, {28'h0, owner});
		chk("select_n", {25'h0, es}, {25'h0, select_n});
		chk("bus_cycle", 32'h1, {31'h0, bus_cycle});
		for (k = 0; k < 50; k++) begin
			@(posedge hclk);
			#1;
			if (access_done === 1'b1) break;
			chk("held select_n", {25'h0, es}, {25'h0, select_n});
			chk("held ext_addr", {16'h0, a}, {16'h0, ext_addr});
		end
		tmo(k);
		chk("stretch cycles", n, k);
		chk("idle select_n", 32'h7F, {25'h0, select_n});
		@(posedge hclk);
		#1;
		if (sel >= 0) begin
			chk("device cycles", n + 1, {28'h0, m_len});
			chk("device select", {25'h0, ~es}, {25'h0, m_sel});
			chk("device slips", 32'h0, {24'h0, m_slip});
		end
	endtask : acc

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs;
		rdchk(STR0_ADDR, 32'h3F);
		rdchk(STR1_ADDR, 32'hFF);
		rdchk(CFG_ADDR, {16'h0, CFG_RST});
		rdchk(MAP_ADDR, MAP_RST);
		wr(10'h0F0, 32'hFFFF_FFFF);
		rdchk(10'h0F0, 32'h0);
		wr(STR0_ADDR, 32'hFF);
		rdchk(STR0_ADDR, 32'h3F);
		// Only whole-word writes may land
		hsize <= 3'h0;
		wr(STR0_ADDR, 32'h00);
		hsize <= HSIZE_WORD;
		rdchk(STR0_ADDR, 32'h3F);
		$display("test registers done");
	endtask : t_regs

	task automatic t_internal;
		acc(16'h01F0, OWN_REG, -1, 0);
		acc(16'h0500, OWN_RAM, -1, 0);
		acc(16'hF100, OWN_NONE, -1, 0);
		wr(CFG_ADDR, 32'h0000_0410);
		acc(16'hF100, OWN_EE, -1, 0);
		wr(CFG_ADDR, 32'h0000_1410);
		acc(16'hFF10, OWN_DBG, -1, 0);
		acc(16'h0010, OWN_REG, -1, 0);
		wr(CFG_ADDR, 32'h0000_007F);
		acc(16'h8000, OWN_NONE, -1, 0);
		$display("test internal done");
	endtask : t_internal

	task automatic t_selects;
		wr(STR1_ADDR, 32'h1B);
		wr(STR0_ADDR, 32'h06);
		wr(CFG_ADDR, 32'h0000_087F);
		acc(16'h0200, OWN_EXT_CS, SEL_CS0, 3);
		acc(16'h0280, OWN_EXT_CS, SEL_CS3, 0);
		acc(16'h0300, OWN_EXT_CS, SEL_CS1, 2);
		acc(16'h0380, OWN_EXT_CS, SEL_CS2, 1);
		acc(16'h8000, OWN_EXT_P, SEL_PROGRAM_SELECT_ZERO, 1);
		acc(16'h7000, OWN_EXT_D, SEL_CSD, 2);
		acc(16'hC000, OWN_EXT_REST, SEL_PROGRAM_SELECT_ZERO, 1);
		acc(16'h1000, OWN_EXT_REST, -1, 0);
		wr(CFG_ADDR, 32'h0000_487F);
		acc(16'h1000, OWN_EXT_REST, SEL_PROGRAM_SELECT_ONE, 0);
		wr(CFG_ADDR, 32'h0000_C87F);
		acc(16'h1000, OWN_EXT_REST, SEL_CSD, 2);
		wr(CFG_ADDR, 32'h0000_0C7F);
		acc(16'hF100, OWN_EE, -1, 0);
		$display("test selects done");
	endtask : t_selects

	task automatic t_follow;
		wr(CFG_ADDR, 32'h0000_0B7F);
		acc(16'h0210, OWN_EXT_E, SEL_CS3, 0);
		acc(16'h0390, OWN_EXT_E, SEL_CS3, 0);
		wr(CFG_ADDR, 32'h0000_097F);
		acc(16'h0280, OWN_EXT_CS, SEL_CS0, 3);
		wr(MAP_ADDR, 32'h000F_1000);
		wr(CFG_ADDR, 32'h0000_2B7F);
		acc(16'h0600, OWN_EXT_E, SEL_CS3, 0);
		acc(16'h0280, OWN_EXT_CS, SEL_CS0, 3);
		rdchk(STAT_ADDR, 32'h0000_0036);
		$display("test follow done");
	endtask : t_follow

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_internal();
		t_selects();
		t_follow();
		end_sim();
	end

endmodule : tb_top
`default_nettype wire
